// file: hw/lgs_top.sv
// Gate input-select register bank with source muxes and gates 1 to 3
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module lgs_top #(
  parameter int unsigned N_SRC = 64
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Source signals
  input wire logic [N_SRC-1:0] src_in,
  // Selected inputs and gate results
  output logic [3:0] selected_input,
  output logic [2:0] gate_out
);
  // Source count must fit the 6-bit select
  if (N_SRC < 1 || N_SRC > 64)
  begin : g_bad_n_src
    $error("N_SRC must be 1 to 64");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] gate_sel_r [3];
  logic [5:0] src_sel_r [4];
  logic [3:0] sel_in;
  logic [2:0] gate_c;
  logic [7:0] rdata_nxt;

  function automatic logic [1:0] gate_idx(input logic [3:0] a);
    return a[1:0];
  endfunction

  // Only power-on reset touches selects; rst leaves them unchanged
  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      for (int g = 0; g < 3; g++)
        gate_sel_r[g] <= lgs_pkg::SEL_POR_VAL;
    end
    else if (wr && (addr == lgs_pkg::OFF_GATE1_SEL || addr == lgs_pkg::OFF_GATE2_SEL
                    || addr == lgs_pkg::OFF_GATE3_SEL))
      gate_sel_r[gate_idx(addr)] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      for (int d = 0; d < 4; d++)
        src_sel_r[d] <= lgs_pkg::SRC_POR_VAL;
    end
    else if (wr && addr[3:2] == lgs_pkg::OFF_DATA1_SRC[3:2])
      src_sel_r[gate_idx(addr)] <= wdata[5:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Source muxes and gates
  always_comb
  begin
    for (int d = 0; d < 4; d++)
      sel_in[d] = (32'(src_sel_r[d]) < N_SRC) ? src_in[src_sel_r[d]] : 1'b0;
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_gate
    lgs_gate u_gate (
      .sel_in(sel_in),
      .sel_byte(gate_sel_r[g]),
      .gate_out(gate_c[g])
    );
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      selected_input <= 4'h0;
      gate_out <= 3'h0;
    end
    else
    begin
      selected_input <= sel_in;
      gate_out <= gate_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb
  begin
    rdata_nxt = lgs_pkg::READ_ZERO;
    unique case (addr)
      lgs_pkg::OFF_GATE1_SEL, lgs_pkg::OFF_GATE2_SEL, lgs_pkg::OFF_GATE3_SEL:
        rdata_nxt = gate_sel_r[gate_idx(addr)];
      lgs_pkg::OFF_DATA1_SRC, lgs_pkg::OFF_DATA2_SRC, lgs_pkg::OFF_DATA3_SRC, lgs_pkg::OFF_DATA4_SRC:
        rdata_nxt = {2'b00, src_sel_r[gate_idx(addr)]};
      lgs_pkg::OFF_GATE_OUT:
        rdata_nxt = {1'b0, gate_out, selected_input};
      default:
        rdata_nxt = lgs_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_WRITE_G1: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_GATE1_SEL |=> gate_sel_r[0] == $past(wdata))
    else $error("gate1 select not written");
  AST_WRITE_G2: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_GATE2_SEL |=> gate_sel_r[1] == $past(wdata))
    else $error("gate2 select not written");
  AST_WRITE_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_GATE3_SEL |=> gate_sel_r[2] == $past(wdata))
    else $error("gate3 select not written");
  AST_TRUE_TERM: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[0][7] && sel_in[3] |=> gate_out[0])
    else $error("true term not gated");
  AST_INV_TERM: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[1][0] && !sel_in[0] |=> gate_out[1])
    else $error("inverted term not gated");
  AST_MAP_D4: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[2] == 8'h80 |=> gate_out[2] == $past(sel_in[3]))
    else $error("data 4 not mapped to input 3");
  AST_KEEP_RST: assert property (@(posedge clk) disable iff (por_rst)
    rst && !wr |=> gate_sel_r[0] == $past(gate_sel_r[0]))
    else $error("select lost on reset");
  AST_SRC_MUX: assert property (@(posedge clk) disable iff (rst || por_rst)
    src_sel_r[1] == 6'h00 |-> sel_in[1] == src_in[0])
    else $error("source select wrong");
  AST_EMPTY_ZERO: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[0] == 8'h00 |=> !gate_out[0])
    else $error("empty gate not zero");

  ////////////////////////////////////////////////////////////////////////
  // Read path checks
  AST_READ_G1: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_GATE1_SEL |=> rdata == $past(gate_sel_r[0]))
    else $error("gate1 select read wrong");

  AST_READ_G2: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_GATE2_SEL |=> rdata == $past(gate_sel_r[1]))
    else $error("gate2 select read wrong");

  AST_READ_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_GATE3_SEL |=> rdata == $past(gate_sel_r[2]))
    else $error("gate3 select read wrong");

  AST_READ_SRC1: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_DATA1_SRC |=> rdata == {2'b00, $past(src_sel_r[0])})
    else $error("data1 source read wrong");

  AST_READ_SRC2: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_DATA2_SRC |=> rdata == {2'b00, $past(src_sel_r[1])})
    else $error("data2 source read wrong");

  AST_READ_SRC3: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_DATA3_SRC |=> rdata == {2'b00, $past(src_sel_r[2])})
    else $error("data3 source read wrong");

  AST_READ_SRC4: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_DATA4_SRC |=> rdata == {2'b00, $past(src_sel_r[3])})
    else $error("data4 source read wrong");

  AST_READ_STATUS: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == lgs_pkg::OFF_GATE_OUT |=> rdata == {1'b0, $past(gate_out), $past(selected_input)})
    else $error("status read wrong");

  AST_READ_IDLE: assert property (@(posedge clk) disable iff (rst || por_rst)
    !rd |=> rdata == 8'h00)
    else $error("read data not idle");

  AST_READ_HOLE: assert property (@(posedge clk) disable iff (rst || por_rst)
    rd && addr == 4'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////
  // Register write, hold and reset checks
  AST_WRITE_SRC1: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_DATA1_SRC |=> src_sel_r[0] == $past(wdata[5:0]))
    else $error("data1 source not written");

  AST_WRITE_SRC2: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_DATA2_SRC |=> src_sel_r[1] == $past(wdata[5:0]))
    else $error("data2 source not written");

  AST_WRITE_SRC3: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_DATA3_SRC |=> src_sel_r[2] == $past(wdata[5:0]))
    else $error("data3 source not written");

  AST_WRITE_SRC4: assert property (@(posedge clk) disable iff (rst || por_rst)
    wr && addr == lgs_pkg::OFF_DATA4_SRC |=> src_sel_r[3] == $past(wdata[5:0]))
    else $error("data4 source not written");

  AST_HOLD_G1: assert property (@(posedge clk) disable iff (rst || por_rst)
    !wr |=> gate_sel_r[0] == $past(gate_sel_r[0]))
    else $error("gate1 select changed");

  AST_HOLD_G2: assert property (@(posedge clk) disable iff (rst || por_rst)
    !wr |=> gate_sel_r[1] == $past(gate_sel_r[1]))
    else $error("gate2 select changed");

  AST_HOLD_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    !wr |=> gate_sel_r[2] == $past(gate_sel_r[2]))
    else $error("gate3 select changed");

  AST_HOLD_SRC1: assert property (@(posedge clk) disable iff (rst || por_rst)
    !wr |=> src_sel_r[0] == $past(src_sel_r[0]))
    else $error("data1 source changed");

  AST_KEEP_RST_G2: assert property (@(posedge clk) disable iff (por_rst)
    rst && !wr |=> gate_sel_r[1] == $past(gate_sel_r[1]))
    else $error("gate2 select lost on reset");

  AST_KEEP_RST_G3: assert property (@(posedge clk) disable iff (por_rst)
    rst && !wr |=> gate_sel_r[2] == $past(gate_sel_r[2]))
    else $error("gate3 select lost on reset");

  AST_POR_CLEAR: assert property (@(posedge clk)
    por_rst |=> gate_sel_r[0] == lgs_pkg::SEL_POR_VAL && gate_sel_r[1] == lgs_pkg::SEL_POR_VAL
      && gate_sel_r[2] == lgs_pkg::SEL_POR_VAL)
    else $error("power-on value not loaded");

  AST_RST_OUT: assert property (@(posedge clk)
    rst |=> gate_out == 3'h0 && selected_input == 4'h0 && rdata == 8'h00)
    else $error("outputs not cleared on reset");

  ////////////////////////////////////////////////////////////////////////
  // Gate term, selected-input register and data1 source mux checks
  AST_TRUE_TERM_G2: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[1][5] && sel_in[2] |=> gate_out[1])
    else $error("gate2 true term not gated");

  AST_TRUE_TERM_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[2][1] && sel_in[0] |=> gate_out[2])
    else $error("gate3 true term not gated");

  AST_INV_TERM_G1: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[0][6] && !sel_in[3] |=> gate_out[0])
    else $error("gate1 inverted term not gated");

  AST_INV_TERM_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[2][2] && !sel_in[1] |=> gate_out[2])
    else $error("gate3 inverted term not gated");

  AST_ONLY_INV: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[0] == 8'h01 |=> gate_out[0] == !$past(sel_in[0]))
    else $error("lone inverted term wrong");

  AST_EMPTY_ZERO_G2: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[1] == 8'h00 |=> !gate_out[1])
    else $error("empty gate2 not zero");

  AST_EMPTY_ZERO_G3: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[2] == 8'h00 |=> !gate_out[2])
    else $error("empty gate3 not zero");

  AST_SEL_PIPE: assert property (@(posedge clk) disable iff (rst || por_rst)
    1'b1 |=> selected_input == $past(sel_in))
    else $error("selected input not registered");

  AST_MAP_D1: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[0] == 8'h02 |=> gate_out[0] == $past(sel_in[0]))
    else $error("data 1 not mapped to input 0");

  AST_MAP_D2: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[1] == 8'h08 |=> gate_out[1] == $past(sel_in[1]))
    else $error("data 2 not mapped to input 1");

  AST_MAP_D3: assert property (@(posedge clk) disable iff (rst || por_rst)
    gate_sel_r[2] == 8'h20 |=> gate_out[2] == $past(sel_in[2]))
    else $error("data 3 not mapped to input 2");

  AST_SRC_MUX0: assert property (@(posedge clk) disable iff (rst || por_rst)
    src_sel_r[0] == 6'h00 |-> sel_in[0] == src_in[0])
    else $error("data1 source select wrong");
endmodule
`default_nettype wire

// file: hw/lgs_pkg.sv
// Package of register map, field layout and sizes for the gate input-select bank
package lgs_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SRC_SEL_W = 6;
  localparam int unsigned N_DATA = 4;
  localparam int unsigned N_GATE = 3;
  // Register offsets
  localparam logic [3:0] OFF_GATE1_SEL = 4'h0;
  localparam logic [3:0] OFF_GATE2_SEL = 4'h1;
  localparam logic [3:0] OFF_GATE3_SEL = 4'h2;
  localparam logic [3:0] OFF_DATA1_SRC = 4'h4;
  localparam logic [3:0] OFF_DATA2_SRC = 4'h5;
  localparam logic [3:0] OFF_DATA3_SRC = 4'h6;
  localparam logic [3:0] OFF_DATA4_SRC = 4'h7;
  localparam logic [3:0] OFF_GATE_OUT = 4'h8;
  // Field positions: data n true at bit 2n-1, inverted at bit 2n-2
  localparam int unsigned TRUE_OFS = 1;
  localparam int unsigned INV_OFS = 0;
  // Power-on value of select registers, unknown in silicon
  localparam logic [7:0] SEL_POR_VAL = 8'h00;
  localparam logic [5:0] SRC_POR_VAL = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// file: hw/lgs_gate.sv
// One gate: OR of enabled true and inverted selected-input terms
`timescale 1ns/100ps
`default_nettype none
module lgs_gate (
  // Selected inputs, index 0 is data 1
  input wire logic [3:0] sel_in,
  // Select byte
  input wire logic [7:0] sel_byte,
  // Gate result
  output logic gate_out
);
  always_comb
  begin
    gate_out = 1'b0;
    for (int i = 0; i < lgs_pkg::N_DATA; i++)
    begin
      gate_out = gate_out | (sel_byte[2*i+lgs_pkg::TRUE_OFS] & sel_in[i]);
      gate_out = gate_out | (sel_byte[2*i+lgs_pkg::INV_OFS] & ~sel_in[i]);
    end
  end
endmodule
`default_nettype wire

// file: sim/lgs_src_model.sv
// Source signal model: registered source pattern
`timescale 1ns/100ps
`default_nettype none
module lgs_src_model (
  // Clock and pattern
  input wire logic clk,
  input wire logic [63:0] pat,
  // Source signals
  output logic [63:0] src
);
  always_ff @(posedge clk)
  begin
    src <= pat;
  end
endmodule
`default_nettype wire

// file: sim/logic_cell_gate_input_select_bench.sv
// Bench for the gate input-select bank
`timescale 1ns/100ps
`default_nettype none
module logic_cell_gate_input_select_bench;
  logic clk = 0, rst = 1, por_rst = 1, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0, selected_input, s;
  logic [7:0] wdata = 8'h00, rdata;
  logic [7:0] m [3];
  logic [2:0] gate_out, g;
  logic [63:0] pat = 64'h0, src_in;
  logic [31:0] lf = 32'h71e3;
  logic [5:0] ix [4];
  int n_errors = 0, samples_checked = 0;
  always #4 clk = ~clk;
  lgs_src_model pm (.clk(clk), .pat(pat), .src(src_in));
  lgs_top dut (.clk(clk), .rst(rst), .por_rst(por_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_in(src_in), .selected_input(selected_input), .gate_out(gate_out));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic gt(input logic [7:0] b, input logic [3:0] d);
    return |(b & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic report_and_stop;
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rreg(i[3:0], 8'h00);
      lf = nx(lf);
      wreg(i[3:0], lf[7:0]);
      rreg(i[3:0], lf[7:0]);
    end
    rreg(4'hf, 8'h00);
    wreg(4'h1, 8'ha5);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rreg(4'h1, 8'ha5);
    $display("register test done");
    for (int k = 0; k < 40; k++)
    begin
      lf = nx(lf);
      for (int j = 0; j < 4; j++)
      begin
        ix[j] = lf[6*j +: 6];
        wreg(4'h4 + j[3:0], {2'b00, ix[j]});
      end
      lf = nx(lf);
      for (int i = 0; i < 3; i++)
      begin
        m[i] = (k == 0) ? 8'h00 : lf[8*i +: 8];
        wreg(i[3:0], m[i]);
      end
      lf = nx(lf);
      pat <= {lf, nx(lf)};
      repeat (5) @(posedge clk);
      #1;
      for (int j = 0; j < 4; j++)
        s[j] = pat[ix[j]];
      for (int i = 0; i < 3; i++)
        g[i] = gt(m[i], s);
      chk({4'h0, selected_input}, {4'h0, s});
      chk({5'h00, gate_out}, {5'h00, g});
      rreg(4'h8, {1'b0, g, s});
      for (int j = 0; j < 4; j++)
        rreg(4'h4 + j[3:0], {2'b00, ix[j]});
    end
    $display("gate test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
